// File: rtl/isg_gate.sv
// Contract
// - Global enable clear blocks every request
// - Bit 6 gates counter array request
// - Bits 5,3,1 gate timer overflow requests
// - Bits 2,0 gate external interrupt requests
// - Main enable resets zero, bit set/clear
// - Enabled keypad line flag raises request
// - Disabled keypad line stays plain I/O
// - Keypad line enable resets to zero
module isg_gate
(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire isg_pkg::isg_src_s   srcFlag,
    input  wire logic [7:0]          keypadLineFlag,
    output isg_pkg::isg_src_s        srcIrqReq,
    output logic                     keypadIrqReq,
    output logic      [7:0]          keypadLineMode,
    output logic                     irqOut
);

    // Flags pass where both enables are set
    function automatic logic [7:0] gateFlags(input logic [7:0] flags, input logic [7:0] en, input logic glob);
        gateFlags = flags & en & {8{glob}};
    endfunction

    // Write-one bit update
    function automatic logic [7:0] bitUpdate(input logic [7:0] old, input logic [7:0] setBits,
                                             input logic [7:0] clrBits);
        bitUpdate = (old | setBits) & ~clrBits;
    endfunction

    logic [7:0]           ien;
    logic [7:0]           keypad_line_enable;
    logic [7:0]           evStatus;
    logic [7:0]           evMask;
    isg_pkg::isg_dphase_s dphase;

    wire                  addrTaken;
    wire                  addrMapped;
    wire [7:0]            addrIndex;
    wire                  wrEn;
    wire [7:0]            wrData;
    wire                  wrIen;
    wire                  wrSet;
    wire                  wrClr;
    wire                  wrKbe;
    wire                  wrMask;
    wire                  rdStatus;
    wire [7:0]            next_ien;
    wire [7:0]            next_kbe;
    wire [7:0]            next_evMask;
    wire [7:0]            next_evStatus;
    wire [7:0]            statusSet;
    wire [7:0]            statusView;
    wire [7:0]            gatedSrc;
    wire [6:0]            next_srcReq;
    wire [7:0]            next_keyLines;
    wire                  next_keypadReq;
    wire                  next_irqOut;
    logic [7:0]           rdByte;

    // Address phase decode
    assign addrTaken  = hsel && hready && (htrans == isg_pkg::HTRANS_NONSEQ);
    assign addrMapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    assign addrIndex  = haddr[9:2];

    // Data phase write strobes
    assign wrEn    = dphase.valid && dphase.write;
    assign wrData  = hwdata[7:0];
    assign wrIen   = wrEn && (dphase.index == isg_pkg::IDX_INTERRUPT_ENABLE);
    assign wrSet   = wrEn && (dphase.index == isg_pkg::IDX_ENABLE_SET);
    assign wrClr   = wrEn && (dphase.index == isg_pkg::IDX_ENABLE_CLEAR);
    assign wrKbe   = wrEn && (dphase.index == isg_pkg::IDX_KEYPAD_LINE_ENABLE);
    assign wrMask  = wrEn && (dphase.index == isg_pkg::IDX_EVENT_MASK);

    // Whole byte write, or write-one-per-bit set and clear
    assign next_ien = wrIen ? wrData :
                      bitUpdate(ien, wrSet ? wrData : 8'h00, wrClr ? wrData : 8'h00);
    assign next_kbe    = wrKbe ? wrData : keypad_line_enable;
    assign next_evMask = wrMask ? wrData : evMask;

    // Request gating
    assign gatedSrc    = gateFlags({1'b0, srcFlag}, {1'b0, ien[6:0]},
                                   ien[isg_pkg::BIT_GLOBAL_IRQ_ENABLE]);
    assign next_srcReq = gatedSrc[6:0];
    assign next_keyLines  = gateFlags(keypadLineFlag, keypad_line_enable, 1'b1);
    assign next_keypadReq = (|next_keyLines) && ien[isg_pkg::BIT_GLOBAL_IRQ_ENABLE];

    // Sticky events, set wins over read clear
    assign statusSet     = {keypadIrqReq, srcIrqReq};
    assign statusView    = evStatus | statusSet;
    assign rdStatus      = addrTaken && !hwrite && addrMapped && (addrIndex == isg_pkg::IDX_EVENT_STATUS);
    assign next_evStatus = rdStatus ? statusSet : statusView;
    assign next_irqOut   = |(next_evStatus & evMask);

    // Read mux sees pending writes
    always_comb
    begin
        rdByte = 8'h00;
        if (addrMapped)
        begin
            case (addrIndex)
                isg_pkg::IDX_INTERRUPT_ENABLE:   rdByte = next_ien;
                isg_pkg::IDX_ENABLE_SET:         rdByte = next_ien;
                isg_pkg::IDX_ENABLE_CLEAR:       rdByte = next_ien;
                isg_pkg::IDX_KEYPAD_LINE_ENABLE: rdByte = next_kbe;
                isg_pkg::IDX_EVENT_STATUS:       rdByte = statusView;
                isg_pkg::IDX_EVENT_MASK:         rdByte = next_evMask;
                isg_pkg::IDX_REQUEST_VIEW:       rdByte = {keypadIrqReq, srcIrqReq};
                default:                         rdByte = 8'h00;
            endcase
        end
    end

    // Bus slave
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dphase    <= '0;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp     <= isg_pkg::HRESP_OKAY;
        end
        else
        begin
            hreadyout    <= 1'b1;
            hresp        <= isg_pkg::HRESP_OKAY;
            if (hready)
            begin
                dphase.valid <= addrTaken && addrMapped;
                dphase.write <= hwrite;
                dphase.index <= addrIndex;
            end
            if (addrTaken && !hwrite)
            begin
                hrdata <= {24'h000000, rdByte};
            end
        end
    end

    // Enable registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ien    <= isg_pkg::RST_INTERRUPT_ENABLE;
            keypad_line_enable    <= isg_pkg::RST_KEYPAD_LINE_ENABLE;
            evMask <= isg_pkg::RST_EVENT_MASK;
        end
        else
        begin
            ien    <= next_ien;
            keypad_line_enable    <= next_kbe;
            evMask <= next_evMask;
        end
    end

    // Requests, line mode and interrupt
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            srcIrqReq      <= '0;
            keypadIrqReq   <= 1'b0;
            keypadLineMode <= isg_pkg::RST_KEYPAD_LINE_ENABLE;
            evStatus       <= isg_pkg::RST_EVENT_STATUS;
            irqOut         <= 1'b0;
        end
        else
        begin
            srcIrqReq      <= next_srcReq;
            keypadIrqReq   <= next_keypadReq;
            keypadLineMode <= keypad_line_enable;
            evStatus       <= next_evStatus;
            irqOut         <= next_irqOut;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    global_block_a: assert property (!ien[7] |=> (srcIrqReq == '0) && !keypadIrqReq)
        else $error("request passed with global enable clear");

    counter_gate_a: assert property (1'b1 |=> srcIrqReq.counterArray ==
                                     $past(srcFlag.counterArray && ien[6] && ien[7]))
        else $error("counter array request mis-gated");

    timer_gate_a: assert property (1'b1 |=>
        (srcIrqReq.timer2Overflow == $past(srcFlag.timer2Overflow && ien[5] && ien[7])) &&
        (srcIrqReq.timer1Overflow == $past(srcFlag.timer1Overflow && ien[3] && ien[7])) &&
        (srcIrqReq.timer0Overflow == $past(srcFlag.timer0Overflow && ien[1] && ien[7])))
        else $error("timer overflow request mis-gated");

    external_gate_a: assert property (1'b1 |=>
        (srcIrqReq.externalIrq1 == $past(srcFlag.externalIrq1 && ien[2] && ien[7])) &&
        (srcIrqReq.externalIrq0 == $past(srcFlag.externalIrq0 && ien[0] && ien[7])))
        else $error("external request mis-gated");

    serial_gate_a: assert property (1'b1 |=> srcIrqReq.serialPort ==
                                    $past(srcFlag.serialPort && ien[4] && ien[7]))
        else $error("serial port request mis-gated");

    bit_set_a: assert property ((wrSet && !wrClr) |=> ((ien & $past(wrData)) == $past(wrData)) &&
                                ((ien & ~$past(wrData)) == ($past(ien) & ~$past(wrData))))
        else $error("bit set access wrong");

    bit_clear_a: assert property (wrClr |=> (ien & $past(wrData)) == 8'h00)
        else $error("bit clear access wrong");

    reset_zero_a: assert property (disable iff (1'b0) rst |-> (ien == 8'h00) && (keypad_line_enable == 8'h00) &&
                                   !keypadIrqReq && (keypadLineMode == 8'h00))
        else $error("enables not zero in reset");

    keypad_raise_a: assert property (((keypadLineFlag & keypad_line_enable) != 8'h00) && ien[7] |=> keypadIrqReq)
        else $error("enabled keypad flag raised no request");

    keypad_plain_a: assert property (((keypadLineFlag & keypad_line_enable) == 8'h00) |=>
                                     !keypadIrqReq && (keypadLineMode == $past(keypad_line_enable)))
        else $error("disabled keypad line raised request");

    irq_level_a: assert property ((evStatus & evMask) != 8'h00 |-> ##[0:1] irqOut)
        else $error("interrupt output missing");

    // Bus and register checks
    bus_ready_a: assert property (1'b1 |=>
                                  hreadyout && (hresp == isg_pkg::HRESP_OKAY))
        else $error("bus not ready or not okay");

    ien_write_a: assert property (wrIen |=>
                                  ien == $past(wrData))
        else $error("main enable write lost");

    ien_hold_a: assert property (!wrIen && !wrSet && !wrClr |=>
                                 ien == $past(ien))
        else $error("main enable changed without write");

    kbe_write_a: assert property (wrKbe |=>
                                  keypad_line_enable == $past(wrData))
        else $error("keypad enable write lost");

    kbe_hold_a: assert property (!wrKbe |=>
                                 keypad_line_enable == $past(keypad_line_enable))
        else $error("keypad enable changed without write");

    mask_write_a: assert property (wrMask |=>
                                   evMask == $past(wrData))
        else $error("mask write lost");

    unmapped_drop_a: assert property ((addrTaken && !addrMapped) |=>
                                      !dphase.valid)
        else $error("unmapped access accepted");

    read_upper_a: assert property (1'b1 |->
                                   hrdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    // Status and interrupt checks
    status_hold_a: assert property (!rdStatus |=>
                                    (evStatus & $past(evStatus)) == $past(evStatus))
        else $error("status bit lost without read");

    status_set_a: assert property (1'b1 |=>
                                   (evStatus & $past(statusSet)) == $past(statusSet))
        else $error("event did not set status");

    status_clear_a: assert property (rdStatus |=>
                                     evStatus == $past(statusSet))
        else $error("status read clear wrong");

    irq_follow_a: assert property (1'b1 |=>
                                   irqOut == ((evStatus & $past(evMask)) != 8'h00))
        else $error("interrupt output mismatch");

    mode_copy_a: assert property (1'b1 |=>
                                  keypadLineMode == $past(keypad_line_enable))
        else $error("keypad line mode mismatch");

    keypad_gate_a: assert property (1'b1 |=>
                                    keypadIrqReq == $past(((keypadLineFlag & keypad_line_enable) != 8'h00) && ien[7]))
        else $error("keypad request mis-gated");

    ien_write_c:  cover property (wrIen ##1 ien[7]);
    status_clear_c: cover property (rdStatus && (statusSet != 8'h00));
    keypad_mode_c: cover property ($changed(keypadLineMode));
    keypad_req_c: cover property ($rose(keypadIrqReq));
    irq_clear_c:  cover property (irqOut ##1 rdStatus ##2 !irqOut);

endmodule

// File: rtl/isg_pkg.sv
package isg_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_KEYPAD_LINE_ENABLE = 8'h9d;
    localparam logic [7:0]  IDX_INTERRUPT_ENABLE   = 8'ha8;
    localparam logic [7:0]  IDX_ENABLE_SET         = 8'hb0;
    localparam logic [7:0]  IDX_ENABLE_CLEAR       = 8'hb1;
    localparam logic [7:0]  IDX_EVENT_STATUS       = 8'hb2;
    localparam logic [7:0]  IDX_EVENT_MASK         = 8'hb3;
    localparam logic [7:0]  IDX_REQUEST_VIEW       = 8'hb4;

    // Field positions of the main enable register, and of the keypad event bit of event status
    localparam int          BIT_GLOBAL_IRQ_ENABLE  = 7;
    localparam int          BIT_COUNTER_ARRAY      = 6;
    localparam int          BIT_TIMER2_OVERFLOW    = 5;
    localparam int          BIT_SERIAL_PORT        = 4;
    localparam int          BIT_TIMER1_OVERFLOW    = 3;
    localparam int          BIT_EXTERNAL_IRQ1      = 2;
    localparam int          BIT_TIMER0_OVERFLOW    = 1;
    localparam int          BIT_EXTERNAL_IRQ0      = 0;
    localparam int          BIT_KEYPAD_EVENT       = 7;

    // Reset values
    localparam logic [7:0]  RST_INTERRUPT_ENABLE   = 8'h00;
    localparam logic [7:0]  RST_KEYPAD_LINE_ENABLE = 8'h00;
    localparam logic [7:0]  RST_EVENT_STATUS       = 8'h00;
    localparam logic [7:0]  RST_EVENT_MASK         = 8'h00;

    // AHB encodings
    localparam logic [1:0]  HTRANS_NONSEQ          = 2'h2;
    localparam logic        HRESP_OKAY             = 1'h0;

    // Sources in main enable register bit order 6..0
    typedef struct packed {
        logic counterArray;
        logic timer2Overflow;
        logic serialPort;
        logic timer1Overflow;
        logic externalIrq1;
        logic timer0Overflow;
        logic externalIrq0;
    } isg_src_s;

    // Captured AHB address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] index;
    } isg_dphase_s;

endpackage

// File: dv/isg_src_model.sv
module isg_src_model
(
    input  wire logic              core_clk,
    input  wire logic [6:0]        wantSrc,
    input  wire logic [7:0]        wantKey,
    output isg_pkg::isg_src_s      srcFlag,
    output logic      [7:0]        keypadLineFlag
);
    timeunit 1ns;
    timeprecision 1ps;
    // Flags move just after the edge, as the sources do
    always_ff @(posedge core_clk)
    begin
        srcFlag        <= wantSrc;
        keypadLineFlag <= wantKey;
    end
endmodule

// File: dv/test_interrupt_source_enable_gating.sv
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_interrupt_source_enable_gating;
    timeunit 1ns;
    timeprecision 1ps;
    logic                core_clk = 1'b0;
    logic                rst = 1'b0;
    logic                hsel = 1'b0;
    logic [31:0]         haddr = 32'h0;
    logic [1:0]          htrans = 2'h0;
    logic                hwrite = 1'b0;
    logic [31:0]         hwdata = 32'h0;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    logic [6:0]          wantSrc = 7'h00;
    logic [7:0]          wantKey = 8'h00;
    isg_pkg::isg_src_s   srcFlag;
    logic [7:0]          keypadLineFlag;
    isg_pkg::isg_src_s   srcIrqReq;
    logic                keypadIrqReq;
    logic [7:0]          keypadLineMode;
    logic                irqOut;
    logic [31:0]         rdata;
    int                  errors = 0;
    int                  n_compared = 0;

    isg_gate uut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .srcFlag(srcFlag), .keypadLineFlag(keypadLineFlag),
        .srcIrqReq(srcIrqReq), .keypadIrqReq(keypadIrqReq), .keypadLineMode(keypadLineMode),
        .irqOut(irqOut));
    isg_src_model partner (.core_clk(core_clk), .wantSrc(wantSrc), .wantKey(wantKey),
        .srcFlag(srcFlag), .keypadLineFlag(keypadLineFlag));

    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= isg_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= {24'h0, d};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rdata = hrdata;
        `CHK(hresp, isg_pkg::HRESP_OKAY)
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset;
        xfer(1'b0, isg_pkg::IDX_INTERRUPT_ENABLE, 8'h00);
        `CHK(rdata, 32'h0)
        xfer(1'b0, isg_pkg::IDX_KEYPAD_LINE_ENABLE, 8'h00);
        `CHK(rdata, 32'h0)
        `CHK(keypadLineMode, 8'h00)
        xfer(1'b0, 8'h10, 8'h00);
        `CHK(rdata, 32'h0)
        $display("reset values done");
    endtask

    task automatic t_sources;
        wantSrc <= 7'h7f;
        for (int i = 0; i < 7; i++)
        begin
            xfer(1'b1, isg_pkg::IDX_INTERRUPT_ENABLE, 8'h80 | (8'h01 << i));
            settle(2);
            `CHK(srcIrqReq, 7'h01 << i)
        end
        `CHK(irqOut, 1'b0)
        xfer(1'b1, isg_pkg::IDX_INTERRUPT_ENABLE, 8'h7f);
        settle(2);
        `CHK(srcIrqReq, 7'h00)
        xfer(1'b1, isg_pkg::IDX_ENABLE_SET, 8'h80);
        xfer(1'b0, isg_pkg::IDX_INTERRUPT_ENABLE, 8'h00);
        `CHK(rdata, 32'hff)
        xfer(1'b1, isg_pkg::IDX_ENABLE_CLEAR, 8'h7e);
        settle(2);
        `CHK(srcIrqReq, 7'h01)
        wantSrc <= 7'h00;
        $display("source gating done");
    endtask

    task automatic t_keypad;
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, isg_pkg::IDX_KEYPAD_LINE_ENABLE, 8'h01 << i);
            wantKey <= 8'h01 << i;
            settle(3);
            `CHK(keypadLineMode, 8'h01 << i)
            `CHK(keypadIrqReq, 1'b1)
            wantKey <= ~(8'h01 << i);
            settle(3);
            `CHK(keypadIrqReq, 1'b0)
        end
        wantKey <= 8'h00;
        $display("keypad lines done");
    endtask

    task automatic t_irq;
        xfer(1'b0, isg_pkg::IDX_EVENT_STATUS, 8'h00);
        `CHK(rdata, 32'hff)
        xfer(1'b1, isg_pkg::IDX_EVENT_MASK, 8'h01);
        xfer(1'b1, isg_pkg::IDX_INTERRUPT_ENABLE, 8'h81);
        wantSrc <= 7'h01;
        settle(5);
        `CHK(irqOut, 1'b1)
        wantSrc <= 7'h00;
        settle(4);
        `CHK(irqOut, 1'b1)
        xfer(1'b0, isg_pkg::IDX_EVENT_STATUS, 8'h00);
        `CHK(rdata, 32'h01)
        settle(3);
        `CHK(irqOut, 1'b0)
        xfer(1'b0, isg_pkg::IDX_EVENT_STATUS, 8'h00);
        `CHK(rdata, 32'h00)
        $display("interrupt output done");
    endtask

    task automatic results;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #100us;
        errors++;
        results();
    end

    initial
    begin
        rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_sources();
        t_keypad();
        t_irq();
        results();
    end
endmodule
